// File: design/wkt_timer.sv
// wake-up down-counter timer top with register port and source select
// assumes oscillator ticks arrive as clock-synchronous single-cycle pulses
`timescale 1ns/1ps
module wkt_timer (
	// clock, reset, enable
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// counting sources: single-cycle oscillator tick pulses and an event pin level that is synchronised here
	input wire logic i_high_speed_internal_osc,
	input wire logic i_low_speed_internal_osc,
	input wire logic i_high_speed_external_osc,
	input wire logic i_low_speed_external_osc,
	input wire logic i_external_event_pin,
	// system state
	input wire logic i_debug_halt,
	input wire logic i_deep_sleep_state,
	// outputs
	output logic o_irq,
	output logic o_wake,
	output logic o_underflow
);
	logic en;
	logic [1:0] mode;
	logic [3:0] prescaler_select;
	logic [2:0] src;
	logic [15:0] reload_value;
	logic [15:0] down_counter;
	logic irq_en;
	logic underflow_flag;
	logic debug_freeze_control;
	logic en_d;
	logic evt_s1;
	logic evt_s2;
	logic evt_s3;
	logic raw;
	logic src_ok;
	logic frozen;
	logic wr_ctl;
	logic start;
	logic uf;
	wkt_tick_if tif();

	// register write strobes
	assign wr_ctl = i_ce && i_wr && i_addr == wkt_pkg::OFS_CONTROL;

	// control register fields
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			en <= 1'b0;
			mode <= wkt_pkg::MODE_RESET;
			prescaler_select <= wkt_pkg::PRS_RESET;
			src <= wkt_pkg::SRC_RESET;
		end else if (wr_ctl) begin
			en <= i_wdata[wkt_pkg::CTL_EN_BIT];
			mode <= i_wdata[wkt_pkg::CTL_MODE_LSB +: 2];
			prescaler_select <= i_wdata[wkt_pkg::CTL_PRS_LSB +: 4];
			src <= i_wdata[wkt_pkg::CTL_SRC_LSB +: 3];
		end
	end

	// reload, interrupt enable and debug freeze registers
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			reload_value <= wkt_pkg::RELOAD_RESET;
			irq_en <= 1'b0;
			debug_freeze_control <= 1'b0;
		end else if (i_ce && i_wr) begin
			if (i_addr == wkt_pkg::OFS_RELOAD) begin
				reload_value <= i_wdata[15:0];
			end
			if (i_addr == wkt_pkg::OFS_IRQ_ENABLE) begin
				irq_en <= i_wdata[wkt_pkg::UD_BIT];
			end
			if (i_addr == wkt_pkg::OFS_DEBUG_FREEZE) begin
				debug_freeze_control <= i_wdata[0];
			end
		end
	end

	// event pin synchroniser and rising-edge detect
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			evt_s1 <= 1'b0;
			evt_s2 <= 1'b0;
			evt_s3 <= 1'b0;
		end else if (i_ce) begin
			evt_s1 <= i_external_event_pin;
			evt_s2 <= evt_s1;
			evt_s3 <= evt_s2;
		end
	end

	// source multiplexer; unlisted codes give no ticks
	always_comb begin
		raw = 1'b0;
		src_ok = 1'b1;
		unique case (src)
			wkt_pkg::WKT_SRC_HSI: raw = i_high_speed_internal_osc;
			wkt_pkg::WKT_SRC_LSI: raw = i_low_speed_internal_osc;
			wkt_pkg::WKT_SRC_HSE: raw = i_high_speed_external_osc;
			wkt_pkg::WKT_SRC_LSE: raw = i_low_speed_external_osc;
			wkt_pkg::WKT_SRC_EVT: raw = evt_s2 && !evt_s3;
			default: src_ok = 1'b0;
		endcase
	end

	// in deep sleep only the slow oscillators keep running
	assign frozen = (debug_freeze_control && i_debug_halt)
		|| (i_deep_sleep_state && src != wkt_pkg::WKT_SRC_LSI
		&& src != wkt_pkg::WKT_SRC_LSE);
	assign start = en && !en_d;
	assign tif.raw_tick = raw && src_ok && en && !start && !frozen;
	assign tif.prescaler_select = prescaler_select;
	assign tif.clear = !en || start;

	wkt_prescaler u_prescaler (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.tif(tif)
	);

	assign uf = tif.tick && down_counter == 16'h0000;

	// enable edge tracker
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			en_d <= 1'b0;
		end else if (i_ce) begin
			en_d <= en;
		end
	end

	// down counter: load on start, count ticks, reload on underflow
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			down_counter <= wkt_pkg::COUNT_RESET;
		end else if (i_ce) begin
			if (start) begin
				down_counter <= reload_value;
			end else if (uf) begin
				down_counter <= reload_value;
			end else if (tif.tick) begin
				down_counter <= down_counter - 16'h0001;
			end
		end
	end

	// underflow flag: a set in the clearing cycle wins
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			underflow_flag <= 1'b0;
		end else if (i_ce) begin
			if (uf) begin
				underflow_flag <= 1'b1;
			end else if (i_wr && i_addr == wkt_pkg::OFS_FLAG_CLEAR
				&& !i_wdata[wkt_pkg::UD_BIT]) begin
				underflow_flag <= 1'b0;
			end
		end
	end

	// registered outputs
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_irq <= 1'b0;
			o_wake <= 1'b0;
			o_underflow <= 1'b0;
		end else if (i_ce) begin
			o_irq <= (underflow_flag || uf) && irq_en;
			o_wake <= (underflow_flag || uf) && irq_en
				&& i_deep_sleep_state;
			o_underflow <= uf;
		end
	end

	// read data, valid in the cycle after the read strobe
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_rdata <= 32'h0000_0000;
		end else if (i_ce) begin
			o_rdata <= 32'h0000_0000;
			if (i_rd) begin
				unique case (i_addr)
					wkt_pkg::OFS_CONTROL:
						o_rdata <= {21'h000000, src, prescaler_select, 1'b0, mode, en};
					wkt_pkg::OFS_RELOAD: o_rdata <= {16'h0000, reload_value};
					wkt_pkg::OFS_COUNT: o_rdata <= {16'h0000, down_counter};
					wkt_pkg::OFS_IRQ_ENABLE:
						o_rdata <= {28'h0000000, irq_en, 3'h0};
					wkt_pkg::OFS_FLAGS:
						o_rdata <= {28'h0000000, underflow_flag, 3'h0};
					wkt_pkg::OFS_FLAG_CLEAR: o_rdata <= 32'h0000_003f;
					wkt_pkg::OFS_DEBUG_FREEZE:
						o_rdata <= {31'h00000000, debug_freeze_control};
					default: o_rdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// checks on the counting behaviour
	a_start_load: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && start) |=> down_counter == $past(reload_value))
		else $error("counter not loaded at start");
	a_tick_dec: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && !start && tif.tick && down_counter != 16'h0000)
		|=> down_counter == $past(down_counter) - 16'h0001)
		else $error("counter did not decrement");
	a_idle_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && !en && en_d == en) |=> $stable(down_counter))
		else $error("counter moved while disabled");
	a_flag_set: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && uf) |=> underflow_flag)
		else $error("underflow flag not set");
	a_uf_reload: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && uf && !start)
		|=> down_counter == $past(reload_value))
		else $error("no reload at underflow");
	a_irq_follow: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && underflow_flag && irq_en) |=> o_irq)
		else $error("interrupt missing");
	a_flag_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && !uf && i_wr && i_addr == wkt_pkg::OFS_FLAG_CLEAR
		&& !i_wdata[wkt_pkg::UD_BIT]) |=> !underflow_flag)
		else $error("flag clear failed");
	a_freeze_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && en && en_d && debug_freeze_control && i_debug_halt)
		|=> $stable(down_counter))
		else $error("counted while frozen");
	a_single_prs: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(prescaler_select == 4'h1 && tif.tick) |=> !tif.tick)
		else $error("divide by two gave back-to-back ticks");
	c_underflow: cover property (@(posedge i_ref_clk) uf && irq_en);
	c_event_src: cover property (@(posedge i_ref_clk)
		src == wkt_pkg::WKT_SRC_EVT && tif.tick);
	c_frozen: cover property (@(posedge i_ref_clk) en && frozen);
endmodule

// File: design/wkt_pkg.sv
// package of constants for the wake-up down-counter timer
// assumes a single 100 MHz clock and a plain register port
// Behaviour
// - counter is 16 bits, counts down only
// - enable set copies reload into counter
// - each prescaled tick at a nonzero count decrements counter by one
// - a tick while counter is zero sets underflow flag and reloads
// - interrupt high while flag and enable set
// - period equals reload plus one ticks
// - clearing enable stops counting
// - slow oscillators keep counting in deep sleep
// - prescaler code k divides by two^k
// - debug freeze bit pauses counting when halted
// - new reload takes effect next period
// - source select maps four oscillators and the external event pin
// - writing zero clears flag, one ignored
package wkt_pkg;
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_RELOAD = 8'h04;
	localparam logic [7:0] OFS_COUNT = 8'h08;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10;
	localparam logic [7:0] OFS_FLAGS = 8'h14;
	localparam logic [7:0] OFS_FLAG_CLEAR = 8'h1c;
	localparam logic [7:0] OFS_DEBUG_FREEZE = 8'h20;
	localparam int CTL_EN_BIT = 0;
	localparam int CTL_MODE_LSB = 1;
	localparam int CTL_PRS_LSB = 4;
	localparam int CTL_SRC_LSB = 8;
	localparam int UD_BIT = 3;
	localparam logic [15:0] RELOAD_RESET = 16'hffff;
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [3:0] PRS_RESET = 4'h0;
	localparam logic [2:0] SRC_RESET = 3'h0;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [14:0] DIV_RESET = 15'h0000;
	typedef enum logic [2:0] {
		WKT_SRC_HSI = 3'h0,
		WKT_SRC_LSI = 3'h1,
		WKT_SRC_HSE = 3'h2,
		WKT_SRC_LSE = 3'h3,
		WKT_SRC_EVT = 3'h4
	} wkt_src_t;
endpackage

// File: design/wkt_if.sv
// interface carrying the prescaler settings and the tick to the counter
// assumes both ends run on the one block clock
`timescale 1ns/1ps
interface wkt_tick_if;
	logic raw_tick;
	logic [3:0] prescaler_select;
	logic clear;
	logic tick;
	modport ctl (output raw_tick, output prescaler_select, output clear, input tick);
	modport div (input raw_tick, input prescaler_select, input clear, output tick);
endinterface

// File: design/wkt_prescaler.sv
// power-of-two prescaler: passes one tick per 2^prs source ticks
// assumes raw ticks are single-cycle pulses on the block clock
`timescale 1ns/1ps
module wkt_prescaler (
	// clock and control
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// settings and tick
	wkt_tick_if.div tif
);
	logic [14:0] div_cnt;
	logic [14:0] mask;
	// mask of low prs bits: wrap point of the divider
	always_comb begin
		mask = 15'h0000;
		for (int b = 0; b < 15; b++) begin
			if (b < int'(tif.prescaler_select)) begin
				mask[b] = 1'b1;
			end
		end
	end
	// divider counter, restarted whenever the timer is idle
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || (i_ce && tif.clear)) begin
			div_cnt <= wkt_pkg::DIV_RESET;
		end else if (i_ce && tif.raw_tick) begin
			div_cnt <= ((div_cnt & mask) == mask) ? wkt_pkg::DIV_RESET
				: div_cnt + 15'h0001;
		end
	end
	// one tick per full divider wrap
	assign tif.tick = tif.raw_tick && !tif.clear &&
		((div_cnt & mask) == mask);
endmodule

// File: dv/wkt_event_src.sv
// partner model: a source of edges on the external event pin
// assumes the block clock; the pin rests low between bursts
`timescale 1ns/1ps
module wkt_event_src (
	// clock and request
	input wire logic i_ref_clk,
	input wire logic i_go,
	input wire logic [7:0] i_edges,
	// pin and status
	output logic o_pin,
	output logic o_busy
);
	logic [7:0] left = 8'h00;
	logic [2:0] ph = 3'h0;
	// each edge: three cycles high then three low, wide enough to sync
	always @(posedge i_ref_clk) begin
		if (i_go) begin
			left <= i_edges;
			ph <= 3'h0;
		end else if (left != 8'h00) begin
			ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
			if (ph == 3'h5) begin
				left <= left - 8'h01;
			end
		end
	end
	assign o_pin = (left != 8'h00) && (ph < 3'h3);
	assign o_busy = left != 8'h00;
endmodule

// File: dv/test_wakeup_down_counter.sv
// self-checking bench for the wake-up down-counter timer
// assumes source ticks every other cycle and a plain register port
`timescale 1ns/1ps
`define CHK(w, e, g) begin n_checks++; if ((g) !== (e)) begin \
	err_total++; $display("CHECK FAILED %s expected %h seen %h", \
	w, e, g); end end
module test_wakeup_down_counter;
	logic i_ref_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
	logic i_debug_halt = 1'b0, i_deep_sleep_state = 1'b0;
	logic src_tick = 1'b0, ev_go = 1'b0, ev_pin, ev_busy;
	logic [7:0] i_addr = 8'h00, ev_n = 8'h00;
	logic [31:0] i_wdata = 32'h0, o_rdata, rv, sv;
	logic [3:0] osc_on = 4'hf;
	logic o_irq, o_wake, o_underflow;
	int err_total = 0, n_checks = 0, n;
	// clock and a source tick on every other cycle
	always #5 i_ref_clk = ~i_ref_clk;
	always @(posedge i_ref_clk) src_tick <= ~src_tick;
	wkt_timer dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(1'b1),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_high_speed_internal_osc(src_tick & osc_on[0]),
		.i_low_speed_internal_osc(src_tick & osc_on[1]),
		.i_high_speed_external_osc(src_tick & osc_on[2]),
		.i_low_speed_external_osc(src_tick & osc_on[3]),
		.i_external_event_pin(ev_pin), .i_debug_halt(i_debug_halt),
		.i_deep_sleep_state(i_deep_sleep_state), .o_irq(o_irq),
		.o_wake(o_wake), .o_underflow(o_underflow));
	wkt_event_src ev (.i_ref_clk(i_ref_clk), .i_go(ev_go),
		.i_edges(ev_n), .o_pin(ev_pin), .o_busy(ev_busy));
	// control word: source, prescaler, mode 11, enable
	function automatic logic [31:0] ctl(input int s, input int p, input bit e);
		return {21'h0, 3'(s), 4'(p), 1'b0, 2'h3, e};
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1 rv = o_rdata;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		`CHK("register", e, rv)
	endtask
	// configure in order, then enable last
	task automatic start(input int s, input int p, input logic [15:0] r);
		wr(8'h00, ctl(s, p, 1'b0));
		wr(8'h10, 32'h8);
		wr(8'h04, {16'h0, r});
		wr(8'h00, ctl(s, p, 1'b1));
	endtask
	task automatic stop;
		wr(8'h00, 32'h0);
		wr(8'h1c, 32'h0);
	endtask
	// cycles until the next underflow pulse
	task automatic wait_uf;
		n = 0;
		do begin
			@(posedge i_ref_clk);
			#1 n++; // look once the edge's updates have settled
		end while (o_underflow !== 1'b1 && n < 3000);
	endtask
	task automatic burst(input logic [7:0] e);
		@(posedge i_ref_clk);
		ev_go <= 1'b1;
		ev_n <= e;
		@(posedge i_ref_clk);
		ev_go <= 1'b0;
		// busy only shows after the updates of the edge at which the model takes the request
		@(posedge i_ref_clk);
		for (int i = 0; i < 100 && ev_busy; i++) @(posedge i_ref_clk);
		repeat (8) @(posedge i_ref_clk);
	endtask
	task automatic t_regs;
		rc(8'h00, 32'h0);
		rc(8'h04, 32'hffff);
		rc(8'h14, 32'h0);
		rc(8'h1c, 32'h3f);
		wr(8'h08, 32'hffff);
		rc(8'h08, 32'h0);
		rc(8'h0c, 32'h0);
	endtask
	task automatic t_period;
		for (int p = 1; p < 4; p++) begin
			start(0, p, 16'h3);
			wait_uf;
			wait_uf;
			`CHK("period", 8 << p, n)
		end
		`CHK("irq", 1'b1, o_irq)
		`CHK("wake", 1'b0, o_wake)
		wr(8'h1c, 32'h8);
		rc(8'h14, 32'h8);
		wr(8'h00, ctl(0, 1, 1'b0));
		rd(8'h08);
		sv = rv;
		repeat (20) @(posedge i_ref_clk);
		rc(8'h08, sv);
		wr(8'h1c, 32'h0);
		rc(8'h14, 32'h0);
		repeat (2) @(posedge i_ref_clk);
		`CHK("irq", 1'b0, o_irq)
	endtask
	task automatic t_reload;
		start(0, 3, 16'h5);
		rc(8'h08, 32'h5);
		wr(8'h04, 32'h40);
		rd(8'h08);
		`CHK("count kept", 1'b1, rv <= 32'h5)
		wait_uf;
		wait_uf;
		`CHK("new period", 1040, n)
		stop;
	endtask
	task automatic t_src;
		for (int k = 0; k < 4; k++) begin
			osc_on <= 4'h1 << k;
			start(k, 1, 16'h3);
			wait_uf;
			wait_uf;
			`CHK("source", 16, n)
			stop;
		end
		osc_on <= 4'hf;
	endtask
	task automatic t_sleep;
		i_deep_sleep_state <= 1'b1;
		start(1, 1, 16'h3);
		wait_uf;
		repeat (3) @(posedge i_ref_clk);
		`CHK("wake", 1'b1, o_wake)
		stop;
		start(0, 1, 16'h3);
		rd(8'h08);
		sv = rv;
		repeat (40) @(posedge i_ref_clk);
		rc(8'h08, sv);
		stop;
		i_deep_sleep_state <= 1'b0;
	endtask
	task automatic t_debug;
		wr(8'h20, 32'h1);
		start(0, 1, 16'h3);
		i_debug_halt <= 1'b1;
		rd(8'h08);
		sv = rv;
		repeat (30) @(posedge i_ref_clk);
		rc(8'h08, sv);
		wr(8'h20, 32'h0);
		repeat (10) @(posedge i_ref_clk);
		rd(8'h08);
		`CHK("debug run", 1'b1, rv !== sv)
		i_debug_halt <= 1'b0;
		stop;
	endtask
	task automatic t_event;
		start(4, 1, 16'h2);
		burst(8'h05);
		rc(8'h14, 32'h0);
		rc(8'h08, 32'h0);
		burst(8'h01);
		rc(8'h14, 32'h8);
		rc(8'h08, 32'h2);
		stop;
	endtask
	task automatic print_verdict;
		if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		t_regs;
		t_period;
		t_reload;
		t_src;
		t_sleep;
		t_debug;
		t_event;
		print_verdict;
	end
	// watchdog against a hang
	initial begin
		repeat (60000) @(posedge i_ref_clk);
		err_total++;
		print_verdict;
	end
endmodule
